// ### inc/cond_flags_defs.vh
// register map, command fields and encodings of the flag and address unit
`ifndef COND_FLAGS_DEFS_VH
`define COND_FLAGS_DEFS_VH

// register byte offsets (low eight address bits decoded)
`define A_OPA 8'h00
`define A_OPB 8'h04
`define A_IMM 8'h08
`define A_PC 8'h0c
`define A_CMD 8'h10
`define A_RESULT 8'h14
`define A_FLAGS 8'h18
`define A_ADDR 8'h1c
`define A_DATA 8'h20
`define A_STATUS 8'h24
`define A_SP 8'h28

// command register fields
`define F_OP 3:0
`define F_COND 7:4
`define F_SIZE 9:8
`define B_SIGNED 10
`define B_REGFORM 11
`define B_SPBASE 12
`define B_IMMPRES 13
`define B_CONDPRES 14
`define CMD_W 15

// operations
`define OP_ADD 4'h0
`define OP_SUB 4'h1
`define OP_CMP 4'h2
`define OP_CMN 4'h3
`define OP_BRANCH 4'h4
`define OP_ADR 4'h5
`define OP_LOAD 4'h6
`define OP_STORE 4'h7

// access sizes
`define SZ_BYTE 2'b00
`define SZ_HALF 2'b01
`define SZ_WORD 2'b10

// condition codes
`define CC_EQ 4'h0
`define CC_NE 4'h1
`define CC_CS 4'h2
`define CC_CC 4'h3
`define CC_MI 4'h4
`define CC_PL 4'h5
`define CC_VS 4'h6
`define CC_VC 4'h7
`define CC_HI 4'h8
`define CC_LS 4'h9
`define CC_GE 4'ha
`define CC_LT 4'hb
`define CC_GT 4'hc
`define CC_LE 4'hd
`define CC_AL 4'he

// immediate limits and pc bias
`define LIM_SP_WORD 32'h0000_03fc
`define LIM_WORD 32'h0000_007c
`define LIM_HALF 32'h0000_003e
`define LIM_BYTE 32'h0000_001f
`define PC_BIAS 32'h0000_0004

// status bits and flag positions
`define ST_BUSY 0
`define ST_FAULT 1
`define ST_TAKEN 2
`define ST_RANGE 3
`define FL_SHIFT 28

`endif

// ### logic/cond_eval.v
// condition code evaluation against the four arithmetic flags
`timescale 1ns/100ps
`default_nettype none
`include "cond_flags_defs.vh"

module cond_eval (
    input wire [3:0] cond_in,      // condition code
    input wire flag_n_in,          // negative
    input wire flag_z_in,          // zero
    input wire flag_c_in,          // carry
    input wire flag_v_in,          // overflow
    output reg pass_out            // condition satisfied
);

    // pure decode; unknown code 4'hf never passes
    always @* begin
        case (cond_in)
            `CC_EQ: pass_out = flag_z_in;
            `CC_NE: pass_out = ~flag_z_in;
            `CC_CS: pass_out = flag_c_in;
            `CC_CC: pass_out = ~flag_c_in;
            `CC_MI: pass_out = flag_n_in;
            `CC_PL: pass_out = ~flag_n_in;
            `CC_VS: pass_out = flag_v_in;
            `CC_VC: pass_out = ~flag_v_in;
            `CC_HI: pass_out = flag_c_in & ~flag_z_in;
            `CC_LS: pass_out = ~flag_c_in | flag_z_in;
            `CC_GE: pass_out = flag_n_in == flag_v_in;
            `CC_LT: pass_out = flag_n_in != flag_v_in;
            `CC_GT: begin
                pass_out = ~flag_z_in & (flag_n_in == flag_v_in);
            end
            `CC_LE: begin
                pass_out = flag_z_in | (flag_n_in != flag_v_in);
            end
            `CC_AL: pass_out = 1'b1;
            default: pass_out = 1'b0;
        endcase
    end

endmodule // cond_eval
`default_nettype wire

// ### logic/cond_flags_and_ldst_addr.v
// flag unit, branch condition and load/store address unit behind ahb-lite
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cond_flags_defs.vh"

module cond_flags_and_ldst_addr (
    input wire clk_sys_in,             // 20 mhz core clock
    input wire sys_rst_in,             // synchronous, active high
    input wire clk_en_in,              // freezes all state when low
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output wire [31:0] hrdata_out,
    output wire hreadyout_out,
    output wire hresp_out,
    output wire mem_req_out,           // one cycle access strobe
    output wire mem_we_out,            // store when high
    output wire [1:0] mem_size_out,    // byte, half or word
    output wire [31:0] mem_addr_out,
    output wire [31:0] mem_wdata_out,
    input wire [31:0] mem_rdata_in,    // word holding the lanes
    input wire mem_ack_in,             // access finished
    output wire hard_fault_out,        // one cycle fault pulse
    output wire branch_taken_out,      // one cycle redirect pulse
    output wire [3:0] status_word_out  // n z c v
);

    localparam S_IDLE = 2'b00;         // waiting for a command
    localparam S_EXEC = 2'b01;         // evaluating the command
    localparam S_WAIT = 2'b10;         // memory access in flight

    // software visible registers
    reg [31:0] opa_ff;                 // base or first operand
    reg [31:0] opb_ff;                 // offset reg or second operand
    reg [31:0] imm_ff;                 // immediate field
    reg [31:0] pc_ff;                  // current instruction address
    reg [31:0] sp_ff;                  // stack pointer base
    reg [31:0] data_ff;                // store source register
    reg [31:0] result_ff;              // destination register
    reg [31:0] addr_ff;                // last effective address
    reg [3:0] flags_ff;                // application_status_word
    reg [`CMD_W-1:0] cmd_ff;           // latched command
    reg [1:0] state_ff;
    reg fault_ff;                      // sticky alignment fault
    reg range_ff;                      // sticky immediate range error
    reg taken_ff;                      // last branch was taken
    // pulse and memory outputs
    reg fault_pls_ff;
    reg taken_pls_ff;
    reg mem_req_ff;
    reg mem_we_ff;
    reg [1:0] mem_size_ff;
    reg [31:0] mem_wdata_ff;
    // bus slave state
    reg wr_pend_ff;                    // write data phase pending
    reg [7:0] wr_addr_ff;
    reg [31:0] hrdata_ff;

    // command fields
    wire [3:0] op = cmd_ff[`F_OP];
    wire [1:0] sz = cmd_ff[`F_SIZE];
    wire regform = cmd_ff[`B_REGFORM];
    wire spbase = cmd_ff[`B_SPBASE];

    // arithmetic, unbounded in 33 bits
    wire is_sub = (op == `OP_SUB) || (op == `OP_CMP);
    wire [32:0] add_res = {1'b0, opa_ff} + {1'b0, opb_ff};
    wire [32:0] sub_res = {1'b0, opa_ff} + {1'b0, ~opb_ff} + 33'h1;
    wire [32:0] ar = is_sub ? sub_res : add_res;
    wire fl_n = ar[31];
    wire fl_z = (ar[31:0] == 32'h0);
    // carry out of the add; for a subtract it is not-borrow
    wire fl_c = ar[32];
    // same-sign operands (add) or opposite (sub) flipping the sign
    wire same_sgn = (opa_ff[31] == opb_ff[31]);
    wire fl_v = (is_sub ? ~same_sgn : same_sgn)
                & (ar[31] != opa_ff[31]);

    // branch condition; missing suffix behaves as always
    wire [3:0] cond_sel = cmd_ff[`B_CONDPRES] ? cmd_ff[`F_COND]
                                             : `CC_AL;
    wire cond_pass;

    cond_eval u_cond (
        .cond_in(cond_sel),
        .flag_n_in(flags_ff[3]),
        .flag_z_in(flags_ff[2]),
        .flag_c_in(flags_ff[1]),
        .flag_v_in(flags_ff[0]),
        .pass_out(cond_pass)
    );

    // pc as seen by the instruction
    wire [31:0] pc_view = pc_ff + `PC_BIAS;

    // effective address generation
    wire [31:0] imm_eff = cmd_ff[`B_IMMPRES] ? imm_ff
                                             : 32'h0;
    wire [31:0] base = spbase ? sp_ff : opa_ff;
    wire [31:0] ea = regform ? opa_ff + opb_ff
                             : base + imm_eff;

    // immediate range checks, word-sp / word / half / byte
    reg imm_ok;
    always @* begin
        imm_ok = 1'b0;
        if (regform) begin
            imm_ok = 1'b1;
        end else begin
            case (sz)
                `SZ_WORD: begin
                    if (spbase) begin
                        imm_ok = (imm_eff <= `LIM_SP_WORD)
                                 && (imm_eff[1:0] == 2'b00);
                    end else begin
                        imm_ok = (imm_eff <= `LIM_WORD)
                                 && (imm_eff[1:0] == 2'b00);
                    end
                end
                `SZ_HALF: begin
                    // stack base is only offered for words
                    imm_ok = ~spbase && (imm_eff <= `LIM_HALF)
                             && ~imm_eff[0];
                end
                `SZ_BYTE: begin
                    imm_ok = ~spbase
                             && (imm_eff <= `LIM_BYTE);
                end
                default: imm_ok = 1'b0;
            endcase
        end
    end

    // alignment; byte accesses are always aligned
    reg misaligned;
    always @* begin
        case (sz)
            `SZ_WORD: misaligned = (ea[1:0] != 2'b00);
            `SZ_HALF: misaligned = ea[0];
            default: misaligned = 1'b0;
        endcase
    end

    // store data narrowed to the access size
    reg [31:0] st_data;
    always @* begin
        case (sz)
            `SZ_BYTE: st_data = {24'h0, data_ff[7:0]};
            `SZ_HALF: st_data = {16'h0, data_ff[15:0]};
            default: st_data = data_ff;
        endcase
    end

    // pick the addressed lane out of the returned word
    wire [31:0] lane = mem_rdata_in >> {addr_ff[1:0], 3'b000};
    // sign extension exists only in the register form
    wire sx = cmd_ff[`B_SIGNED] & regform;
    reg [31:0] ld_data;
    always @* begin
        case (sz)
            `SZ_BYTE: begin
                ld_data = {{24{sx & lane[7]}}, lane[7:0]};
            end
            `SZ_HALF: begin
                ld_data = {{16{sx & lane[15]}}, lane[15:0]};
            end
            default: ld_data = mem_rdata_in;
        endcase
    end

    // bus address phase; zero wait state when enabled
    wire ahb_go = hsel_in & htrans_in[1] & hready_in & clk_en_in;
    wire [7:0] ra = haddr_in[7:0];
    wire idle = (state_ff == S_IDLE);

    // read mux, sampled at the address phase
    reg [31:0] rd_mux;
    always @* begin
        case (ra)
            `A_OPA: rd_mux = opa_ff;
            `A_OPB: rd_mux = opb_ff;
            `A_IMM: rd_mux = imm_ff;
            `A_PC: rd_mux = pc_ff;
            `A_CMD: rd_mux = {17'h0, cmd_ff};
            `A_RESULT: rd_mux = result_ff;
            `A_FLAGS: rd_mux = {flags_ff, 28'h0};
            `A_ADDR: rd_mux = addr_ff;
            `A_DATA: rd_mux = data_ff;
            `A_STATUS: begin
                rd_mux = {28'h0, range_ff, taken_ff,
                          fault_ff, ~idle};
            end
            `A_SP: rd_mux = sp_ff;
            default: rd_mux = 32'h0;  // unmapped reads as zero
        endcase
    end

    // write decode in the data phase
    wire wr_now = wr_pend_ff & clk_en_in;
    wire wr_opa = wr_now && (wr_addr_ff == `A_OPA);
    wire wr_opb = wr_now && (wr_addr_ff == `A_OPB);
    wire wr_imm = wr_now && (wr_addr_ff == `A_IMM);
    wire wr_pc = wr_now && (wr_addr_ff == `A_PC);
    wire wr_cmd = wr_now && (wr_addr_ff == `A_CMD);
    wire wr_fl = wr_now && (wr_addr_ff == `A_FLAGS);
    wire wr_dat = wr_now && (wr_addr_ff == `A_DATA);
    wire wr_st = wr_now && (wr_addr_ff == `A_STATUS);
    wire wr_sp = wr_now && (wr_addr_ff == `A_SP);

    // hardware events of the execute step
    wire ex = (state_ff == S_EXEC);
    wire is_mem = (op == `OP_LOAD) || (op == `OP_STORE);
    wire mem_bad = ex && is_mem && (~imm_ok || misaligned);
    wire set_fault = ex && is_mem && imm_ok && misaligned;
    wire set_range = ex && is_mem && ~imm_ok;
    wire br_go = ex && (op == `OP_BRANCH) && cond_pass;
    wire fl_upd = ex && ((op == `OP_ADD) || (op == `OP_SUB)
                  || (op == `OP_CMP) || (op == `OP_CMN));

    // bus slave flops
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h0;
            hrdata_ff <= 32'h0;
        end else if (clk_en_in) begin
            // a new address phase replaces any finished one
            if (hready_in) begin
                wr_pend_ff <= ahb_go & hwrite_in;
                wr_addr_ff <= ra;
            end
            if (ahb_go & ~hwrite_in) begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    // software operand registers
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            opa_ff <= 32'h0;
            opb_ff <= 32'h0;
            imm_ff <= 32'h0;
            data_ff <= 32'h0;
            sp_ff <= 32'h0;
        end else if (clk_en_in) begin
            if (wr_opa) opa_ff <= hwdata_in;
            if (wr_opb) opb_ff <= hwdata_in;
            if (wr_imm) imm_ff <= hwdata_in;
            if (wr_dat) data_ff <= hwdata_in;
            if (wr_sp) sp_ff <= hwdata_in;
        end
    end

    // program counter: software load, taken branch redirects
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pc_ff <= 32'h0;
        end else if (clk_en_in) begin
            if (br_go) begin
                pc_ff <= pc_view + imm_eff;
            end else if (wr_pc) begin
                pc_ff <= hwdata_in;
            end
        end
    end

    // flags: only add, sub and the compares touch them
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            flags_ff <= 4'h0;
        end else if (clk_en_in) begin
            if (fl_upd) begin
                flags_ff <= {fl_n, fl_z, fl_c, fl_v};
            end else if (wr_fl) begin
                flags_ff <= hwdata_in[31:`FL_SHIFT];
            end
            // all other operations hold the flags
        end
    end

    // sticky fault and range, plus last-branch taken; a hardware set beats a same-cycle clear
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            fault_ff <= 1'b0;
            range_ff <= 1'b0;
            taken_ff <= 1'b0;
        end else if (clk_en_in) begin
            fault_ff <= set_fault | (fault_ff
                        & ~(wr_st & hwdata_in[`ST_FAULT]));
            range_ff <= set_range | (range_ff
                        & ~(wr_st & hwdata_in[`ST_RANGE]));
            if (ex && (op == `OP_BRANCH)) begin
                taken_ff <= cond_pass;
            end
        end
    end

    // command sequencer and datapath results
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_ff <= S_IDLE;
            cmd_ff <= {`CMD_W{1'b0}};
            result_ff <= 32'h0;
            addr_ff <= 32'h0;
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_size_ff <= `SZ_WORD;
            mem_wdata_ff <= 32'h0;
            fault_pls_ff <= 1'b0;
            taken_pls_ff <= 1'b0;
        end else if (clk_en_in) begin
            mem_req_ff <= 1'b0;
            fault_pls_ff <= set_fault;
            taken_pls_ff <= br_go;
            case (state_ff)
                S_IDLE: begin
                    // commands written while busy are dropped
                    if (wr_cmd) begin
                        cmd_ff <= hwdata_in[`CMD_W-1:0];
                        state_ff <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    state_ff <= S_IDLE;
                    case (op)
                        `OP_ADD, `OP_SUB: result_ff <= ar[31:0];
                        `OP_ADR: begin
                            // flags stay as they are
                            result_ff <= pc_view + imm_eff;
                        end
                        `OP_LOAD, `OP_STORE: begin
                            addr_ff <= ea;
                            // a fault never reaches memory
                            if (~mem_bad) begin
                                mem_req_ff <= 1'b1;
                                mem_we_ff <= (op == `OP_STORE);
                                mem_size_ff <= sz;
                                mem_wdata_ff <= st_data;
                                state_ff <= S_WAIT;
                            end
                        end
                        // compares and branches write no result
                        default: result_ff <= result_ff;
                    endcase
                end
                S_WAIT: begin
                    // memory answers with an ack, any latency
                    if (mem_ack_in) begin
                        if (~mem_we_ff) begin
                            result_ff <= ld_data;
                        end
                        state_ff <= S_IDLE;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // outputs
    assign hrdata_out = hrdata_ff;
    assign hreadyout_out = clk_en_in;  // stalls the bus while frozen
    assign hresp_out = 1'b0;
    assign mem_req_out = mem_req_ff;
    assign mem_we_out = mem_we_ff;
    assign mem_size_out = mem_size_ff;
    assign mem_addr_out = addr_ff;
    assign mem_wdata_out = mem_wdata_ff;
    assign hard_fault_out = fault_pls_ff;
    assign branch_taken_out = taken_pls_ff;
    assign status_word_out = flags_ff;

endmodule // cond_flags_and_ldst_addr
`default_nettype wire

// ### sim/cond_flags_and_ldst_addr_monitor.sv
// concurrent checks on the access and pulse ports of the unit
`timescale 1ns/100ps
`default_nettype none
module cond_flags_and_ldst_addr_monitor (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic mem_req_out,
    input wire logic mem_we_out,
    input wire logic [1:0] mem_size_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic [31:0] mem_wdata_out,
    input wire logic hard_fault_out,
    input wire logic branch_taken_out,
    input wire logic [3:0] status_word_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    // launch, then two quiet cycles, fields held
    sequence s_launch;
        mem_req_out;
    endsequence
    sequence s_settled;
        (!mem_req_out && $stable(mem_addr_out) && $stable(mem_size_out))[*2];
    endsequence
    chk_req_stands: assert property (s_launch |=> s_settled)
        else $error("fields moved after launch");
    chk_flags_held: assert property (
        s_launch |=> $stable(status_word_out)[*3])
        else $error("flags moved in access");
    chk_lane_zero: assert property (
        mem_req_out && mem_we_out && mem_size_out != 2'h2
        |-> (mem_wdata_out >> (8 << mem_size_out)) == 32'h0)
        else $error("store data above size");
    chk_addr_aligned: assert property (
        mem_req_out
        |-> (mem_addr_out & ((32'h1 << mem_size_out) - 32'h1)) == 32'h0)
        else $error("unaligned access launched");
    chk_fault_quiet: assert property (
        hard_fault_out |-> !mem_req_out && !branch_taken_out)
        else $error("fault beside an access");
    chk_fault_pulse: assert property (
        hard_fault_out |=> !hard_fault_out)
        else $error("fault pulse too long");
    chk_taken_pulse: assert property (
        branch_taken_out |=> !branch_taken_out [*2])
        else $error("redirect pulse too long");
    chk_taken_quiet: assert property (
        branch_taken_out |-> !mem_req_out && !hard_fault_out)
        else $error("redirect beside access or fault");
endmodule // cond_flags_and_ldst_addr_monitor
bind cond_flags_and_ldst_addr cond_flags_and_ldst_addr_monitor i_mon (.*);
`default_nettype wire

// ### sim/cond_flags_and_ldst_addr_tb.sv
// self-checking bench for the flag, branch and load/store unit
`timescale 1ns/100ps
`default_nettype none
`include "cond_flags_defs.vh"
module cond_flags_and_ldst_addr_tb;
    logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1;
    logic hsel_in = 1'b0, hwrite_in = 1'b0;
    logic [1:0] htrans_in = 2'h0;
    logic [2:0] hsize_in = 3'h2; // whole words only
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0;
    wire logic [31:0] hrdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
    wire logic hreadyout_out, hresp_out, mem_req_out, mem_we_out, mem_ack_in;
    wire logic hard_fault_out, branch_taken_out;
    wire logic [1:0] mem_size_out;
    wire logic [3:0] status_word_out;
    wire logic hready_in = hreadyout_out; // one slave drives hready
    int err_count = 0, checks_done = 0, nfault = 0, ntaken = 0, nreq = 0;
    logic [31:0] shadow [64], q, a, b, d, imm, pc, res, ad, mk, v;
    logic [31:0] req_addr, req_wdata;
    logic [35:0] e;
    logic [1:0] req_size;
    logic req_we;
    cond_flags_and_ldst_addr i_dut (.*);
    data_mem_model i_mem (
        .clk_in(clk_sys_in),
        .req_in(mem_req_out),
        .we_in(mem_we_out),
        .size_in(mem_size_out),
        .addr_in(mem_addr_out),
        .wdata_in(mem_wdata_out),
        .rdata_out(mem_rdata_in),
        .ack_out(mem_ack_in)
    );
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // pulse counts, copy of each launch
    always @(posedge clk_sys_in) begin
        if (hard_fault_out === 1'b1) nfault++;
        if (branch_taken_out === 1'b1) ntaken++;
        if (mem_req_out === 1'b1) begin
            nreq++;
            {req_addr, req_wdata} = {mem_addr_out, mem_wdata_out};
            {req_size, req_we} = {mem_size_out, mem_we_out};
        end
    end
    task automatic end_sim();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, logic [31:0] x, y);
        checks_done++;
        if (y !== x) begin
            err_count++;
            $display("mismatch %s exp %h got %h", nm, x, y);
        end
    endtask
    // a wait that ran out counts and ends the run
    task automatic tmo(input string nm);
        chk(nm, 32'h1, 32'h0);
        end_sim();
    endtask
    // bounded wait for hready at a rising edge
    task automatic wrdy();
        int n = 0;
        do begin
            @(posedge clk_sys_in);
            if (++n > 99) tmo("hready");
        end while (hready_in !== 1'b1);
    endtask
    // one word transfer; read data in q
    task automatic bus(input logic w, logic [7:0] ad8, logic [31:0] dt);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        hwrite_in <= w;
        haddr_in <= {24'h0, ad8};
        wrdy();
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= dt;
        wrdy();
        q = hrdata_out;
    endtask
    // command, then bounded busy poll
    task automatic run(input logic [14:0] cmd);
        int n = 0;
        bus(1'b1, `A_CMD, {17'h0, cmd});
        do begin
            bus(1'b0, `A_STATUS, 32'h0);
            if (++n > 50) tmo("busy");
        end while (q[`ST_BUSY] !== 1'b0);
    endtask
    // reference {n,z,c,v} and result; subtract carry is no borrow
    function automatic logic [35:0] alu(input logic [1:0] op,
                                        logic [31:0] x, y);
        logic sb;
        logic [32:0] s;
        sb = op == 2'h1 || op == 2'h2;
        s = sb ? {x >= y, x - y} : {1'b0, x} + {1'b0, y};
        return {s[31], s[31:0] == 32'h0, s[32],
                (x[31] ^ y[31]) == sb && s[31] != x[31], s[31:0]};
    endfunction
    // reference condition table
    function automatic logic cpass(input logic [3:0] c, f);
        logic n, z, cy, ov;
        logic [15:0] t;
        {n, z, cy, ov} = f;
        t = {1'b0, 1'b1, z | (n ^ ov), !z & !(n ^ ov), n ^ ov, !(n ^ ov),
             !cy | z, cy & !z, !ov, ov, !n, n, !cy, cy, !z, z};
        return t[c];
    endfunction
    initial begin
        int w, md, ld, sg, bad, r0, f0, t0, lim;
        logic [3:0] fl;
        logic [1:0] sz;
        logic t, rng, mis;
        void'($urandom(32'hd06b0904));
        repeat (12) @(posedge clk_sys_in);
        shadow = i_mem.mem; // memory's opening contents
        sys_rst_in <= 1'b0;
        bus(1'b0, `A_FLAGS, 32'h0);
        chk("flags_rst", 32'h0, q);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        res = 32'h0;
        // add, sub, compares: edge and random operands
        for (int i = 0; i < 48; i++) begin
            a = i < 8 ? 32'h8000_0000 - i[0] : $urandom;
            b = i < 8 ? 32'h8000_0000 - i[1] : i < 12 ? a : i < 16 ? -a : $urandom;
            bus(1'b1, `A_OPA, a);
            bus(1'b1, `A_OPB, b);
            run({13'h0, i[1:0]});
            e = alu(i[1:0], a, b);
            if (i[1] == 1'b0) res = e[31:0];
            bus(1'b0, `A_RESULT, 32'h0);
            chk("result", res, q);
            chk("flags", e[35:32], status_word_out);
        end
        // every condition and flag set, then pc-relative add
        for (int i = 0; i < 288; i++) begin
            fl = 4'(i);
            pc = $urandom;
            b = $urandom % 256 * 4; // aligned, within 1020
            t = cpass(i < 256 ? 4'(i >> 4) : `CC_AL, fl);
            bus(1'b1, `A_FLAGS, {fl, 28'h0});
            bus(1'b1, `A_PC, pc);
            bus(1'b1, `A_IMM, b);
            t0 = ntaken;
            run({i < 256, 1'b1, 5'h0, 4'(i >> 4), `OP_BRANCH});
            chk("taken", t, ntaken - t0);
            pc = t ? pc + `PC_BIAS + b : pc;
            bus(1'b0, `A_PC, 32'h0);
            chk("pc", pc, q);
            run({2'h1, 9'h0, `OP_ADR});
            bus(1'b0, `A_RESULT, 32'h0);
            chk("adr", pc + `PC_BIAS + b, q);
            chk("flags_kept", fl, status_word_out);
        end
        // loads and stores over size, form, sign and errors
        for (int i = 0; i < 144; i++) begin
            sz = 2'(i % 3);
            w = 1 << sz;
            md = i / 3 % 4; // imm, no imm, low regs, sp
            ld = i / 12 % 2;
            sg = i / 24 % 2;
            bad = i / 48; // ok, misaligned, range
            lim = md == 3 ? 1020 : 31 * w;
            imm = bad == 2 ? lim + w : $urandom % (lim / w + 1) * w;
            a = ($urandom & 32'hffff_fffc) + (bad == 1);
            b = $urandom & ~(w - 1);
            ad = a + (md == 2 ? b : md == 1 ? 32'h0 : imm);
            rng = (md == 0 || md == 3) && (bad == 2 || md == 3 && sz != 2'h2);
            mis = !rng && (ad & (w - 1)) != 0;
            mk = sz == 2'h2 ? 32'hffff_ffff : (32'h1 << 8 * w) - 32'h1;
            d = $urandom;
            bus(1'b1, `A_OPA, md == 3 ? ~a : a);
            bus(1'b1, `A_SP, a);
            bus(1'b1, `A_OPB, b);
            bus(1'b1, `A_IMM, imm);
            bus(1'b1, `A_DATA, d);
            r0 = nreq;
            f0 = nfault;
            run({1'b0, md == 0 || md == 3, md == 3, md == 2, sg[0], sz, 4'h0,
                 ld ? `OP_LOAD : `OP_STORE});
            chk("launch", !rng && !mis, nreq - r0);
            chk("fault", mis, nfault - f0);
            bus(1'b0, `A_STATUS, 32'h0);
            chk("range", rng, q[`ST_RANGE]);
            bus(1'b1, `A_STATUS, 32'h0000_000a);
            if (!rng && !mis) begin
                chk("addr", ad, req_addr);
                chk("kind", {~ld[0], sz}, {req_we, req_size});
                v = shadow[ad[7:2]] >> 8 * ad[1:0] & mk;
                if (ld == 0) begin
                    chk("wdata", d & mk, req_wdata);
                    shadow[ad[7:2]] ^= (v ^ d & mk) << 8 * ad[1:0];
                end else begin
                    if (sg && md == 2 && v[8 * w - 1]) v |= ~mk;
                    bus(1'b0, `A_RESULT, 32'h0);
                    chk("load", v, q);
                end
            end
            chk("flags_kept", fl, status_word_out);
        end
        chk("hresp", 32'h0, hresp_out);
        end_sim();
    end
endmodule // cond_flags_and_ldst_addr_tb
`default_nettype wire

// ### sim/data_mem_model.sv
// data memory answering the unit's load/store port
`timescale 1ns/100ps
`default_nettype none
module data_mem_model (
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [1:0] size_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out,
    output logic ack_out
);
    logic [31:0] mem [64];
    logic [31:0] last_ff = 32'h0; // last word out
    logic pend_ff = 1'b0; // an access is open
    logic [1:0] wait_ff = 2'h0; // answer delay
    wire logic [5:0] idx = addr_in[7:2];
    initial for (int i = 0; i < 64; i++) mem[i] = 32'h9c5a_e381 * (i + 1);
    assign ack_out = pend_ff && wait_ff == 2'h0;
    // idle bus shows inverse of last word
    assign rdata_out = ack_out ? mem[idx] : ~last_ff;
    // count down, answer, write lanes on ack
    always @(posedge clk_in) begin
        if (req_in) begin
            pend_ff <= 1'b1;
            wait_ff <= 2'($urandom % 3);
        end else if (wait_ff != 2'h0) begin
            wait_ff <= wait_ff - 2'h1;
        end else if (ack_out) begin
            pend_ff <= 1'b0;
            last_ff <= rdata_out;
            if (we_in) begin
                case (size_in)
                    2'h0: mem[idx][8 * addr_in[1:0] +: 8] <= wdata_in[7:0];
                    2'h1: mem[idx][16 * addr_in[1] +: 16] <= wdata_in[15:0];
                    default: mem[idx] <= wdata_in;
                endcase
            end
        end
    end
endmodule // data_mem_model
`default_nettype wire
